// File: design/mport_map_check.sv
// multiport address entry forward and untag map gating
`timescale 1ns/1ps
`default_nettype none
module mport_map_check
  import vlan_policy_pkg::*;
#(
  parameter int NPORTS = 9
) (
  input  wire logic [MPORT_W-1:0] enables,      // multiport map control bits
  input  wire logic               entry_hit,    // destination from a multiport entry
  input  wire logic [2:0]         entry_idx,    // which entry, 0 to 5
  input  wire logic               src_mgmt,     // frame came from mgmt cpu port
  input  wire logic [NPORTS-1:0]  dest_in,      // destination before vlan checks
  input  wire logic [NPORTS-1:0]  fwd_map,      // vlan table forward map
  input  wire logic [NPORTS-1:0]  untag_map,    // vlan table untag map
  output logic      [NPORTS-1:0]  dest_out,     // destination after forward check
  output logic      [NPORTS-1:0]  untag_out,    // untag map to apply
  output logic                    mport_gated   // a multiport check was applied
);

  // pick one entry's enable: odd bit untag, even bit forward
  function automatic logic entry_en(input logic [MPORT_W-1:0] en,
                                    input logic [2:0] idx,
                                    input logic untag);
    logic [3:0] pos;
    pos = {idx, untag};
    entry_en = (idx < 3'(N_ENTRIES)) ? en[pos] : 1'b0;
  endfunction

  logic fwd_chk;
  logic untag_chk;

  // mgmt port frames never take the multiport checks
  assign fwd_chk   = entry_hit && !src_mgmt && entry_en(enables, entry_idx, 1'b0); // see R10 R11
  assign untag_chk = entry_hit && !src_mgmt && entry_en(enables, entry_idx, 1'b1); // see R09 R11

  // without the check an entry forwards as programmed and leaves tags alone
  always_comb begin
    dest_out  = fwd_chk ? (dest_in & fwd_map) : dest_in;   // see R10
    untag_out = (!entry_hit || untag_chk) ? untag_map : '0; // see R09
    mport_gated = fwd_chk || untag_chk;
  end

endmodule
`default_nettype wire

// File: design/vlan_policy_control.sv
// vlan policy control registers and per-frame forwarding decisions
//
// Notes on behaviour
// R01: tag preserve keeps untagged frames unchanged at egress
// R02: tag preserve ignored in double tagging mode
// R03: trunk bypass set: mgmt directed frames skip trunks
// R04: trunk bypass clear: mgmt directed frames trunk checked
// R05: invalid vid drop set: unknown vid frames dropped
// R06: invalid vid drop clear: unknown vid to mgmt
// R07: all-ones vid forwarded when set, else dropped
// R08: crc bypass set: mgmt port skips crc check
// R09: odd enable bits gate entry untag map check
// R10: even enable bits gate entry forward map check
// R11: multiport checks never apply to mgmt port frames
// R12: multiport control bits 15:12 read zero
// R13: double tagging active only for field value 01
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module vlan_policy_control
  import vlan_policy_pkg::*;
#(
  parameter int NPORTS   = 9,
  parameter int MGMT_BIT = 8
) (
  input  wire logic              core_clk,            // 40 mhz core clock
  input  wire logic              rst,                 // async reset, active high
  // apb slave
  input  wire logic              psel,                // apb select
  input  wire logic              penable,             // apb access phase
  input  wire logic              pwrite,              // apb direction
  input  wire logic [APB_AW-1:0] paddr,               // apb byte address
  input  wire logic [31:0]       pwdata,              // apb write data
  input  wire logic [3:0]        pstrb,               // apb byte strobes
  output logic      [31:0]       prdata,              // apb read data
  output logic                   pready,              // apb ready
  output logic                   pslverr,             // apb error, unmapped
  // frame request from the lookup stage
  input  wire logic              frm_valid,           // one frame to judge
  input  wire logic [VID_W-1:0]  frm_vid,             // frame vlan id
  input  wire logic              frm_vid_known,       // vid has a table entry
  input  wire logic              frm_arrived_tagged,  // arrived with a vlan tag
  input  wire logic              frm_src_mgmt,        // ingress is mgmt cpu port
  input  wire logic              frm_egress_directed, // mgmt frame names its egress
  input  wire logic              frm_crc_ok,          // crc of frame is good
  input  wire logic [NPORTS-1:0] frm_dest_map,        // destination from lookup
  input  wire logic              frm_mport_hit,       // destination is a multiport entry
  input  wire logic [2:0]        frm_mport_idx,       // multiport entry number
  input  wire logic [NPORTS-1:0] vt_fwd_map,          // vlan table forward map
  input  wire logic [NPORTS-1:0] vt_untag_map,        // vlan table untag map
  // decision
  output logic                   dec_valid,           // decision pulse
  output logic                   dec_drop,            // discard frame
  output logic                   dec_to_mgmt,         // sent to mgmt cpu port
  output logic      [NPORTS-1:0] dec_dest_map,        // final destination
  output logic      [NPORTS-1:0] dec_untag_map,       // egress untag map
  output logic                   dec_tag_preserve,    // egress leaves format as received
  output logic                   dec_trunk_check,     // trunk checking applies
  output logic                   dec_crc_checked,     // crc was checked
  output logic                   double_tag_operation // double tagging mode active
);

  // register state
  logic [CTL5_W-1:0]  ctl5_ff;
  logic [MPORT_W-1:0] mport_ff;
  logic [DT_W-1:0]    dt_ff;
  logic [CNT_W-1:0]   drop_cnt_ff;
  logic [CNT_W-1:0]   mgmt_cnt_ff;
  logic [31:0]        prdata_ff;
  logic               pslverr_ff;

  // decision state
  logic               dec_valid_ff;
  logic               dec_drop_ff;
  logic               dec_to_mgmt_ff;
  logic [NPORTS-1:0]  dec_dest_ff;
  logic [NPORTS-1:0]  dec_untag_ff;
  logic               dec_keep_ff;
  logic               dec_trunk_ff;
  logic               dec_crc_ff;

  // bus decode
  logic               setup_phase;
  logic               wr_take;
  logic [7:0]         reg_idx;
  logic               idx_hit;
  logic [31:0]        nxt_prdata;

  // zero wait states: the access cycle completes where it starts
  assign setup_phase = psel && !penable;
  assign wr_take     = psel && penable && pwrite;
  assign reg_idx     = paddr[9:2];

  // true for a word address that holds a register
  function automatic logic is_mapped(input logic [APB_AW-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    is_mapped = (a[APB_AW-1:10] == '0) && (a[1:0] == 2'h0) &&
                (i == CTL5_IDX || i == MPORT_IDX || i == DT_IDX ||
                 i == STAT_IDX || i == DROP_CNT_IDX || i == MGMT_CNT_IDX);
  endfunction

  // one decode feeds the read mux, every write enable and the error flag
  assign idx_hit = is_mapped(paddr);

  // zero wait states; error only on an unmapped address
  assign pready  = psel && penable;
  assign pslverr = psel && penable && pslverr_ff;
  assign prdata  = prdata_ff;

  // read mux, sampled in setup so data stands through the access phase
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    case (reg_idx)
      CTL5_IDX:     nxt_prdata[CTL5_W-1:0] = ctl5_ff;
      MPORT_IDX:    nxt_prdata[MPORT_RD_W-1:0] = {4'h0, mport_ff}; // see R12
      DT_IDX:       nxt_prdata[DT_W-1:0] = dt_ff;
      STAT_IDX: begin
        nxt_prdata[STAT_DT_BIT]   = double_tag_operation;
        nxt_prdata[STAT_BUSY_BIT] = dec_valid_ff;
      end
      DROP_CNT_IDX: nxt_prdata[CNT_W-1:0] = drop_cnt_ff;
      MGMT_CNT_IDX: nxt_prdata[CNT_W-1:0] = mgmt_cnt_ff;
      default:      nxt_prdata = 32'h0000_0000;
    endcase
    if (!idx_hit) begin
      nxt_prdata = 32'h0000_0000;
    end
  end

  // read data and error flag latched in the setup cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup_phase) begin
      prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
      pslverr_ff <= !idx_hit;
    end
  end

  // control five; reserved bits are plain storage and read back
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctl5_ff <= CTL5_RST; // trunk bypass comes up set, see R03
    end else if (wr_take && idx_hit && reg_idx == CTL5_IDX && pstrb[0]) begin
      ctl5_ff <= pwdata[CTL5_W-1:0];
    end
  end

  // multiport map control, two byte lanes; upper nibble is not stored
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mport_ff <= MPORT_RST;
    end else if (wr_take && idx_hit && reg_idx == MPORT_IDX) begin
      if (pstrb[0]) begin
        mport_ff[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        mport_ff[MPORT_W-1:8] <= pwdata[MPORT_W-1:8]; // see R12
      end
    end
  end

  // double tag enable field; reserved codes are stored but stay inactive
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dt_ff <= DT_RST;
    end else if (wr_take && idx_hit && reg_idx == DT_IDX && pstrb[0]) begin
      dt_ff <= pwdata[DT_W-1:0];
    end
  end

  // reserved codes leave double tagging off rather than guess a meaning
  assign double_tag_operation = (dt_ff == DT_ON); // see R13

  // per-frame evaluation
  logic               tag_keep;
  logic               bad_vid;
  logic               all_ones;
  logic               crc_skip;
  logic               crc_bad;
  logic               nxt_drop;
  logic               nxt_to_mgmt;
  logic               nxt_keep;
  logic [NPORTS-1:0]  mp_dest;
  logic [NPORTS-1:0]  mp_untag;
  logic [NPORTS-1:0]  nxt_dest;
  logic [NPORTS-1:0]  nxt_untag;
  logic [NPORTS-1:0]  mgmt_only;

  // one-hot destination naming only the mgmt cpu port
  assign mgmt_only = NPORTS'(1) << MGMT_BIT;

  mport_map_check #(
    .NPORTS      (NPORTS)
  ) u_mport_check (
    .enables     (mport_ff),
    .entry_hit   (frm_mport_hit),
    .entry_idx   (frm_mport_idx),
    .src_mgmt    (frm_src_mgmt),
    .dest_in     (frm_dest_map),
    .fwd_map     (vt_fwd_map),
    .untag_map   (vt_untag_map),
    .dest_out    (mp_dest),
    .untag_out   (mp_untag),
    .mport_gated ()
  );

  // preserve only outside double tagging, and only for untagged arrivals
  assign tag_keep = ctl5_ff[TAG_KEEP_BIT] && !double_tag_operation; // see R01 R02
  assign nxt_keep = tag_keep && !frm_arrived_tagged;                 // see R01

  // the all-ones vid has its own control, so it never counts as unknown
  assign all_ones = (frm_vid == VID_ALL_ONES);
  assign bad_vid  = !frm_vid_known && !all_ones;

  // crc skipped only at the mgmt cpu port and only when bypass is set
  assign crc_skip = frm_src_mgmt && ctl5_ff[CRC_BYP_BIT]; // see R08
  assign crc_bad  = !crc_skip && !frm_crc_ok;             // see R08

  // drop and redirect priority: crc, all-ones vid, unknown vid
  always_comb begin
    nxt_drop    = 1'b0;
    nxt_to_mgmt = 1'b0;
    if (crc_bad) begin
      nxt_drop = 1'b1;
    end else if (all_ones) begin
      nxt_drop = !ctl5_ff[ALL_ONES_FWD_BIT]; // see R07
    end else if (bad_vid) begin
      nxt_drop    = ctl5_ff[BAD_VID_DROP_BIT];  // see R05
      nxt_to_mgmt = !ctl5_ff[BAD_VID_DROP_BIT]; // see R06
    end
  end

  // destination and egress untag map
  always_comb begin
    nxt_dest  = mp_dest;
    nxt_untag = mp_untag;
    if (nxt_drop) begin
      nxt_dest = '0;
    end else if (nxt_to_mgmt) begin
      nxt_dest = mgmt_only; // see R06
    end
    if (nxt_keep) begin
      nxt_untag = '0; // table untag map ignored, see R01
    end
  end

  // decision registers, one cycle after the request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dec_valid_ff   <= 1'b0;
      dec_drop_ff    <= 1'b0;
      dec_to_mgmt_ff <= 1'b0;
      dec_dest_ff    <= '0;
      dec_untag_ff   <= '0;
      dec_keep_ff    <= 1'b0;
      dec_trunk_ff   <= 1'b0;
      dec_crc_ff     <= 1'b0;
    end else begin
      dec_valid_ff <= frm_valid;
      if (frm_valid) begin
        dec_drop_ff    <= nxt_drop;
        dec_to_mgmt_ff <= nxt_to_mgmt;
        dec_dest_ff    <= nxt_dest;
        dec_untag_ff   <= nxt_untag;
        dec_keep_ff    <= nxt_keep;
        dec_crc_ff     <= !crc_skip;
        // mgmt directed frames skip trunks only while bypass is set
        dec_trunk_ff   <= !(frm_src_mgmt && frm_egress_directed &&
                            ctl5_ff[TRUNK_BYP_BIT]); // see R03 R04
      end
    end
  end

  // saturating counters so a long run never wraps to a small value
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drop_cnt_ff <= '0;
    end else if (frm_valid && nxt_drop && drop_cnt_ff != '1) begin
      drop_cnt_ff <= drop_cnt_ff + CNT_W'(1);
    end
  end

  // frames redirected to the mgmt cpu port
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mgmt_cnt_ff <= '0;
    end else if (frm_valid && nxt_to_mgmt && mgmt_cnt_ff != '1) begin
      mgmt_cnt_ff <= mgmt_cnt_ff + CNT_W'(1);
    end
  end

  // decision outputs straight from flip-flops
  assign dec_valid        = dec_valid_ff;
  assign dec_drop         = dec_drop_ff;
  assign dec_to_mgmt      = dec_to_mgmt_ff;
  assign dec_dest_map     = dec_dest_ff;
  assign dec_untag_map    = dec_untag_ff;
  assign dec_tag_preserve = dec_keep_ff;
  assign dec_trunk_check  = dec_trunk_ff;
  assign dec_crc_checked  = dec_crc_ff;

endmodule
`default_nettype wire

// File: design/vlan_policy_pkg.sv
// package: register map, field positions and reset values of the vlan policy block
package vlan_policy_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0]  CTL5_IDX         = 8'h06;
  localparam logic [7:0]  MPORT_IDX        = 8'h0a;
  localparam logic [7:0]  DT_IDX           = 8'h0c;
  localparam logic [7:0]  STAT_IDX         = 8'h0d;
  localparam logic [7:0]  DROP_CNT_IDX     = 8'h0e;
  localparam logic [7:0]  MGMT_CNT_IDX     = 8'h0f;

  // control five fields
  localparam int          CTL5_W           = 8;
  localparam int          TAG_KEEP_BIT     = 6;
  localparam int          TRUNK_BYP_BIT    = 4;
  localparam int          BAD_VID_DROP_BIT = 3;
  localparam int          ALL_ONES_FWD_BIT = 2;
  localparam int          CRC_BYP_BIT      = 0;
  localparam logic [7:0]  CTL5_RST         = 8'h10;

  // multiport map control: bit 2n forward check, bit 2n+1 untag check
  localparam int          MPORT_W          = 12;
  localparam int          MPORT_RD_W       = 16;
  localparam int          N_ENTRIES        = 6;
  localparam logic [11:0] MPORT_RST        = 12'h000;

  // double tag enable field
  localparam int          DT_W             = 2;
  localparam logic [1:0]  DT_RST           = 2'h0;
  localparam logic [1:0]  DT_ON            = 2'h1;

  // vlan id values
  localparam int          VID_W            = 12;
  localparam logic [11:0] VID_ALL_ONES     = 12'hfff;

  // status bit positions
  localparam int          STAT_DT_BIT      = 0;
  localparam int          STAT_BUSY_BIT    = 1;

  localparam int          CNT_W            = 16;
  localparam int          APB_AW           = 12;

endpackage

// File: verification/lookup_stage_model.sv
// behavioural lookup stage that hands the block one frame at a time
`timescale 1ns/1ps
`default_nettype none
module lookup_stage_model
  import vlan_policy_pkg::*;
(
  input  wire logic       core_clk,            // clock
  output logic            frm_valid,           // frame strobe
  output logic [VID_W-1:0] frm_vid,            // vlan id
  output logic            frm_vid_known,       // table hit
  output logic            frm_arrived_tagged,  // had a tag
  output logic            frm_src_mgmt,        // from mgmt port
  output logic            frm_egress_directed, // names egress
  output logic            frm_crc_ok,          // crc good
  output logic [8:0]      frm_dest_map,        // lookup dest
  output logic            frm_mport_hit,       // multiport entry
  output logic [2:0]      frm_mport_idx,       // entry number
  output logic [8:0]      vt_fwd_map,          // table fwd map
  output logic [8:0]      vt_untag_map         // table untag map
);
  // quiet until the first frame
  initial begin
    {frm_valid, frm_vid, frm_dest_map, frm_mport_idx, vt_fwd_map, vt_untag_map} = '0;
    {frm_vid_known, frm_arrived_tagged, frm_src_mgmt, frm_egress_directed} = '0;
    {frm_crc_ok, frm_mport_hit} = '0;
  end
  // flags: known, tagged, mgmt, egress, crc ok, multiport hit
  task automatic send(input logic [11:0] vid, input logic [5:0] fl, input logic [2:0] idx,
                      input logic [8:0] dst, input logic [8:0] fwd, input logic [8:0] utg);
    @(posedge core_clk);
    frm_valid <= 1'b1;
    frm_vid <= vid;
    {frm_vid_known, frm_arrived_tagged, frm_src_mgmt, frm_egress_directed, frm_crc_ok,
     frm_mport_hit} <= fl;
    frm_mport_idx <= idx;
    frm_dest_map <= dst;
    vt_fwd_map <= fwd;
    vt_untag_map <= utg;
    @(posedge core_clk);
    frm_valid <= 1'b0;
    // attributes mean nothing off the strobe, so invert the dest map to keep it from looking valid
    frm_dest_map <= ~dst;
  endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
// testbench: registers, frame decisions and multiport gating of the vlan policy block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vlan_policy_pkg::*;
  logic core_clk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0]  pstrb = 4'hf;
  logic pready, pslverr, frm_valid, frm_vid_known, frm_arrived_tagged, frm_src_mgmt;
  logic frm_egress_directed, frm_crc_ok, frm_mport_hit, dec_valid, dec_drop, dec_to_mgmt;
  logic dec_tag_preserve, dec_trunk_check, dec_crc_checked, double_tag_operation;
  logic [11:0] frm_vid;
  logic [2:0]  frm_mport_idx;
  logic [8:0]  frm_dest_map, vt_fwd_map, vt_untag_map, dec_dest_map, dec_untag_map;
  int n_errors = 0, comparisons = 0;
  vlan_policy_control i_vlan_policy_control (.*);
  lookup_stage_model i_lookup_stage_model (.*);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; holds the request until ready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask
  // decision lands exactly one edge after the strobe
  task automatic fr(input logic [11:0] v, input logic [5:0] f, input logic [2:0] i,
                    input logic [8:0] d, input logic [8:0] fw, input logic [8:0] u);
    i_lookup_stage_model.send(v, f, i, d, fw, u);
    #1;
    chk(dec_valid, 1);
  endtask
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    rdc(12'h018, 32'h10);
    rdc(12'h028, 32'h0);
    wr(12'h028, 32'hffff);
    rdc(12'h028, 32'hfff);
    // only the low byte lane enabled, so the upper enables survive
    pstrb <= 4'h1;
    wr(12'h028, 32'h0);
    pstrb <= 4'hf;
    rdc(12'h028, 32'hf00);
    rdc(12'h038, 32'h0);
    rdc(12'h03c, 32'h0);
    apb(1'b1, 12'h7fc, 32'h1, r, e);
    chk(e, 1);
  endtask
  task automatic t_vid;
    for (int b = 0; b < 2; b++) begin
      wr(12'h018, b ? 32'h0c : 32'h00);
      fr(12'h005, 6'b000010, 3'h0, 9'h003, 9'h1ff, 9'h0);
      chk(dec_drop, b);
      chk(dec_dest_map, b ? 9'h0 : 9'h100);
      chk(dec_to_mgmt, !b);
      fr(12'hfff, 6'b100010, 3'h0, 9'h003, 9'h1ff, 9'h0);
      chk(dec_dest_map, b ? 9'h003 : 9'h0);
    end
  endtask
  task automatic t_mgmt;
    wr(12'h018, 32'h11);
    fr(12'h005, 6'b111100, 3'h0, 9'h003, 9'h1ff, 9'h0);
    chk(dec_trunk_check, 0);
    chk(dec_drop, 0);
    chk(dec_crc_checked, 0);
    fr(12'h005, 6'b100000, 3'h0, 9'h003, 9'h1ff, 9'h0);
    chk(dec_drop, 1);
    chk(dec_crc_checked, 1);
    wr(12'h018, 32'h00);
    fr(12'h005, 6'b111100, 3'h0, 9'h003, 9'h1ff, 9'h0);
    chk(dec_trunk_check, 1);
    chk(dec_drop, 1);
    chk(dec_crc_checked, 1);
  endtask
  // every double tag field code, tag preserve on
  task automatic t_tag;
    wr(12'h018, 32'h40);
    for (int m = 0; m < 4; m++) begin
      wr(12'h030, m);
      rdc(12'h030, m);
      rdc(12'h034, m == 1);
      fr(12'h005, 6'b100010, 3'h0, 9'h003, 9'h1ff, 9'h0f0);
      chk(double_tag_operation, m == 1);
      chk(dec_untag_map, m == 1 ? 9'h0f0 : 9'h0);
      chk(dec_tag_preserve, m != 1);
    end
    fr(12'h005, 6'b110010, 3'h0, 9'h003, 9'h1ff, 9'h0f0);
    chk(dec_tag_preserve, 0);
  endtask
  // walk one enable bit over all six entries
  task automatic t_mport;
    wr(12'h018, 32'h10);
    wr(12'h030, 32'h0);
    for (int n = 0; n < 12; n++) begin
      wr(12'h028, 32'h1 << n);
      fr(12'h005, 6'b100011, 3'(n / 2), 9'h0ff, 9'h0f3, 9'h05a);
      chk(dec_dest_map, n % 2 ? 9'h0ff : 9'h0f3);
      chk(dec_untag_map, n % 2 ? 9'h05a : 9'h0);
      fr(12'h005, 6'b101011, 3'(n / 2), 9'h0ff, 9'h0f3, 9'h05a);
      chk(dec_dest_map, 9'h0ff);
      // an enable for one entry leaves the next entry unchecked
      fr(12'h005, 6'b100011, 3'((n / 2 + 1) % 6), 9'h0ff, 9'h0f3, 9'h05a);
      chk(dec_dest_map, 9'h0ff);
      chk(dec_untag_map, 9'h0);
    end
  endtask
  // totals of the drops and redirects made by the scenarios above
  task automatic t_counts;
    rdc(12'h038, 32'h4);
    rdc(12'h03c, 32'h1);
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_regs;
    t_vid;
    t_mgmt;
    t_tag;
    t_mport;
    t_counts;
    close_out;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    close_out;
  end
endmodule
`default_nettype wire

// File: verification/vlan_policy_properties.sv
// checker: port-level properties of the vlan policy block
`timescale 1ns/1ps
`default_nettype none
module vlan_policy_properties
  import vlan_policy_pkg::*;
#(
  parameter int NPORTS   = 9,
  parameter int MGMT_BIT = 8
) (
  input wire logic              core_clk,             // clock
  input wire logic              rst,                  // reset
  input wire logic              psel,                 // select
  input wire logic              penable,              // access
  input wire logic              pwrite,               // dir
  input wire logic [APB_AW-1:0] paddr,                // addr
  input wire logic [31:0]       pwdata,               // wdata
  input wire logic [3:0]        pstrb,                // strobes
  input wire logic [31:0]       prdata,               // rdata
  input wire logic              frm_valid,            // frame
  input wire logic [VID_W-1:0]  frm_vid,              // vid
  input wire logic              frm_vid_known,        // known
  input wire logic              frm_arrived_tagged,   // tagged
  input wire logic              frm_src_mgmt,         // mgmt src
  input wire logic              frm_egress_directed,  // directed
  input wire logic              frm_crc_ok,           // crc ok
  input wire logic              dec_valid,            // decision
  input wire logic              dec_drop,             // drop
  input wire logic              dec_to_mgmt,          // to mgmt
  input wire logic [NPORTS-1:0] dec_dest_map,         // dest
  input wire logic [NPORTS-1:0] dec_untag_map,        // untag
  input wire logic              dec_tag_preserve,     // preserve
  input wire logic              dec_trunk_check,      // trunk
  input wire logic              dec_crc_checked,      // crc checked
  input wire logic              double_tag_operation  // double_tag_operation
);
  localparam logic [NPORTS-1:0] MGMT_MAP = NPORTS'(1) << MGMT_BIT;
  logic [7:0] ctl5_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // shadow of control five, taken only at the completing edge like the slave
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) ctl5_ff <= CTL5_RST;
    else if (psel && penable && pwrite && paddr == 12'h018 && pstrb[0]) ctl5_ff <= pwdata[7:0];
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_read; psel && penable && !pwrite && paddr == 12'h028; endsequence
  property p_tag_keep;
    logic b;
    (frm_valid && !frm_arrived_tagged && !double_tag_operation, b = ctl5_ff[6]) |=>
      dec_tag_preserve == b && (!b || dec_untag_map == '0);
  endproperty
  property p_dt_mute; frm_valid && double_tag_operation |=> !dec_tag_preserve; endproperty
  property p_trunk;
    logic b;
    (frm_valid && frm_src_mgmt && frm_egress_directed, b = ctl5_ff[4]) |=> dec_trunk_check == !b;
  endproperty
  property p_bad_vid;
    logic b;
    (frm_valid && frm_crc_ok && !frm_vid_known && frm_vid != VID_ALL_ONES, b = ctl5_ff[3])
      |=> dec_drop == b ##0 dec_to_mgmt == !b;
  endproperty
  property p_all_ones;
    logic b;
    (frm_valid && frm_crc_ok && frm_vid == VID_ALL_ONES, b = ctl5_ff[2]) |=> dec_drop == !b;
  endproperty
  property p_crc;
    logic b;
    (frm_valid && frm_src_mgmt, b = ctl5_ff[0]) |=> dec_crc_checked == !b;
  endproperty
  property p_mgmt_dest; dec_valid && dec_to_mgmt |-> dec_dest_map == MGMT_MAP; endproperty
  property p_resv_read; s_setup ##1 s_read |-> prdata[31:12] == 20'h0; endproperty
  a_tag_keep: assert property (p_tag_keep)
    else $error("tag preserve decision wrong");
  a_dt_mute: assert property (p_dt_mute)
    else $error("tag preserve active in double tag mode");
  a_trunk: assert property (p_trunk)
    else $error("trunk check decision wrong");
  a_bad_vid: assert property (p_bad_vid)
    else $error("unknown vid handling wrong");
  a_all_ones: assert property (p_all_ones)
    else $error("all ones vid handling wrong");
  a_crc: assert property (p_crc)
    else $error("mgmt crc check decision wrong");
  a_mgmt_dest: assert property (p_mgmt_dest)
    else $error("to mgmt without mgmt only dest");
  a_resv_read: assert property (p_resv_read)
    else $error("reserved multiport bits not zero");
endmodule
bind vlan_policy_control vlan_policy_properties #(.NPORTS(NPORTS), .MGMT_BIT(MGMT_BIT))
  i_vlan_policy_properties (.*);
`default_nettype wire
